// ===== shared/udesc_pkg.sv
// package of descriptor constants, types and helpers for the descriptor defaults block
// Overview of operation
// - the interface descriptor reads length 09h, type 04h, number 00h, alternate 00h and 03h endpoints.
// - interface class, subclass, protocol and string index come from the loaded image, else FFh, 00h, FFh, 00h.
// - the bulk-in endpoint reads 07h, 05h, address 81h, attributes 02h and interval 00h, all fixed.
// - the bulk-out endpoint reads 07h, 05h, address 02h, attributes 02h and interval 00h, all fixed.
// - both bulk endpoints report 64 bytes at full speed, 512 at high speed and 1024 at SuperSpeed.
// - the interrupt endpoint reads 07h, 05h, address 83h, attributes 03h and packet size 10h, fixed.
// - the interrupt interval comes from the image per FS/HS, else 04h HS, 01h FS, and 06h at SuperSpeed.
// - the other-speed configuration is answered only in USB 2.0 speeds and stalled at SuperSpeed.
// - the other-speed configuration reads length 09h, type 07h, total 0027h, one interface, value 01h.
// - its string index and attributes come from the image, else 00h and 80h with bit 6 set by self powered and bit 5 by remote wakeup.
// - its maximum power comes from the image, else 01h self powered and FAh bus powered.
// - its loaded fields are those of the opposite USB 2.0 speed.
package udesc_pkg;

    typedef enum logic [1:0] {
        UDESC_FS = 2'b00,
        UDESC_HS = 2'b01,
        UDESC_SS = 2'b10
    } udesc_speed_e;

    typedef enum logic [2:0] {
        UDESC_K_IFC  = 3'b000,
        UDESC_K_EPBI = 3'b001,
        UDESC_K_EPBO = 3'b010,
        UDESC_K_EPIN = 3'b011,
        UDESC_K_OSC  = 3'b100
    } udesc_kind_e;

    // byte offsets inside the descriptors
    localparam logic [3:0] OFS_LEN      = 4'h0;
    localparam logic [3:0] OFS_TYPE     = 4'h1;
    localparam logic [3:0] OFS_IF_NUM   = 4'h2;
    localparam logic [3:0] OFS_IF_ALT   = 4'h3;
    localparam logic [3:0] OFS_IF_NEP   = 4'h4;
    localparam logic [3:0] OFS_IF_CLASS = 4'h5;
    localparam logic [3:0] OFS_IF_SUB   = 4'h6;
    localparam logic [3:0] OFS_IF_PROTO = 4'h7;
    localparam logic [3:0] OFS_IF_STR   = 4'h8;
    localparam logic [3:0] OFS_EP_ADDR  = 4'h2;
    localparam logic [3:0] OFS_EP_ATTR  = 4'h3;
    localparam logic [3:0] OFS_EP_MPSL  = 4'h4;
    localparam logic [3:0] OFS_EP_MPSH  = 4'h5;
    localparam logic [3:0] OFS_EP_IVL   = 4'h6;
    localparam logic [3:0] OFS_CF_TOTL  = 4'h2;
    localparam logic [3:0] OFS_CF_TOTH  = 4'h3;
    localparam logic [3:0] OFS_CF_NIF   = 4'h4;
    localparam logic [3:0] OFS_CF_VAL   = 4'h5;
    localparam logic [3:0] OFS_CF_STR   = 4'h6;
    localparam logic [3:0] OFS_CF_ATTR  = 4'h7;
    localparam logic [3:0] OFS_CF_PWR   = 4'h8;

    // interface descriptor
    localparam logic [7:0] IF_LEN       = 8'h09;
    localparam logic [7:0] IF_TYPE      = 8'h04;
    localparam logic [7:0] IF_NUM       = 8'h00;
    localparam logic [7:0] IF_ALT       = 8'h00;
    localparam logic [7:0] IF_NEP       = 8'h03;
    localparam logic [7:0] IF_CLASS_DEF = 8'hFF;
    localparam logic [7:0] IF_SUB_DEF   = 8'h00;
    localparam logic [7:0] IF_PROTO_DEF = 8'hFF;
    localparam logic [7:0] IF_STR_DEF   = 8'h00;

    // endpoint descriptors
    localparam logic [7:0]  EP_LEN       = 8'h07;
    localparam logic [7:0]  EP_TYPE      = 8'h05;
    localparam logic [7:0]  EPBI_ADDR    = 8'h81;
    localparam logic [7:0]  EPBO_ADDR    = 8'h02;
    localparam logic [7:0]  EP_BULK_ATTR = 8'h02;
    localparam logic [7:0]  EP_BULK_IVL  = 8'h00;
    localparam logic [15:0] MPS_FS       = 16'h0040;
    localparam logic [15:0] MPS_HS       = 16'h0200;
    localparam logic [15:0] MPS_SS       = 16'h0400;
    localparam logic [7:0]  EPIN_ADDR    = 8'h83;
    localparam logic [7:0]  EPIN_ATTR    = 8'h03;
    localparam logic [15:0] EPIN_MPS     = 16'h0010;
    localparam logic [7:0]  IVL_HS_DEF   = 8'h04;
    localparam logic [7:0]  IVL_FS_DEF   = 8'h01;
    localparam logic [7:0]  IVL_SS       = 8'h06;

    // other-speed configuration descriptor
    localparam logic [7:0]  OSC_LEN      = 8'h09;
    localparam logic [7:0]  OSC_TYPE     = 8'h07;
    localparam logic [15:0] OSC_TOTAL    = 16'h0027;
    localparam logic [7:0]  OSC_NIF      = 8'h01;
    localparam logic [7:0]  OSC_CFGV     = 8'h01;
    localparam logic [7:0]  OSC_STR_DEF  = 8'h00;
    localparam logic [7:0]  OSC_ATTR_RSV = 8'h80;
    localparam int          ATTR_SP_BIT  = 6;
    localparam int          ATTR_RW_BIT  = 5;
    localparam logic [7:0]  OSC_PWR_SELF = 8'h01;
    localparam logic [7:0]  OSC_PWR_BUS  = 8'hFA;
    localparam logic [7:0]  BYTE_NONE    = 8'h00;

    typedef struct packed {
        logic [7:0] str;
        logic [7:0] attr;
        logic [7:0] pwr;
    } udesc_cfg_s;

    // image fields handed over by the non-volatile loader
    typedef struct packed {
        logic [7:0] if_class;
        logic [7:0] if_sub;
        logic [7:0] if_proto;
        logic [7:0] if_str;
        logic [7:0] ivl_fs;
        logic [7:0] ivl_hs;
        udesc_cfg_s cfg_fs;
        udesc_cfg_s cfg_hs;
    } udesc_nvm_s;

    // values in force for the current speed
    typedef struct packed {
        logic [7:0]  if_class;
        logic [7:0]  if_sub;
        logic [7:0]  if_proto;
        logic [7:0]  if_str;
        logic [15:0] bulk_mps;
        logic [7:0]  int_ivl;
        udesc_cfg_s  osc;
        logic        osc_stall;
    } udesc_eff_s;

    typedef struct packed {
        udesc_kind_e kind;
        logic [3:0]  ofs;
    } udesc_req_s;

    typedef struct packed {
        logic       valid;
        logic       stall;
        logic [7:0] data;
    } udesc_rsp_s;

    typedef struct packed {
        udesc_speed_e speed;
        logic         nvm_held;
        logic         nvm_ok;
        udesc_nvm_s   nvm;
        udesc_rsp_s   rsp;
    } udesc_state_s;

    function automatic logic [7:0] udesc_half(input logic [15:0] v, input logic hi);
        udesc_half = hi ? v[15:8] : v[7:0];
    endfunction : udesc_half

endpackage : udesc_pkg

// ===== hdl/udesc_speed_sel.sv
// picks the speed dependent and image dependent descriptor values
`timescale 1ns/100ps
module udesc_speed_sel (
    // current state
    input  wire udesc_pkg::udesc_speed_e speed_i,
    input  wire logic                    nvm_ok_i,
    input  wire udesc_pkg::udesc_nvm_s   nvm_i,
    // configuration flags
    input  wire logic                    self_powered_i,
    input  wire logic                    rwake_en_i,
    // selected values
    output udesc_pkg::udesc_eff_s        eff_o
);
    logic [7:0] def_attr;
    logic [7:0] def_pwr;

    always_comb
    begin
        def_attr = udesc_pkg::OSC_ATTR_RSV;
        def_attr[udesc_pkg::ATTR_SP_BIT] = self_powered_i;
        def_attr[udesc_pkg::ATTR_RW_BIT] = rwake_en_i;
        def_pwr = self_powered_i ? udesc_pkg::OSC_PWR_SELF : udesc_pkg::OSC_PWR_BUS;
        eff_o.if_class = nvm_ok_i ? nvm_i.if_class : udesc_pkg::IF_CLASS_DEF;
        eff_o.if_sub   = nvm_ok_i ? nvm_i.if_sub   : udesc_pkg::IF_SUB_DEF;
        eff_o.if_proto = nvm_ok_i ? nvm_i.if_proto : udesc_pkg::IF_PROTO_DEF;
        eff_o.if_str   = nvm_ok_i ? nvm_i.if_str   : udesc_pkg::IF_STR_DEF;
        eff_o.osc.str  = udesc_pkg::OSC_STR_DEF;
        eff_o.osc.attr = def_attr;
        eff_o.osc.pwr  = def_pwr;
        eff_o.osc_stall = 1'b0;
        eff_o.bulk_mps = udesc_pkg::MPS_FS;
        eff_o.int_ivl  = udesc_pkg::IVL_FS_DEF;
        unique case (speed_i)
            udesc_pkg::UDESC_FS:
            begin
                eff_o.bulk_mps = udesc_pkg::MPS_FS;
                eff_o.int_ivl = nvm_ok_i ? nvm_i.ivl_fs : udesc_pkg::IVL_FS_DEF;
                if (nvm_ok_i)
                    eff_o.osc = nvm_i.cfg_hs;
            end
            udesc_pkg::UDESC_HS:
            begin
                eff_o.bulk_mps = udesc_pkg::MPS_HS;
                eff_o.int_ivl = nvm_ok_i ? nvm_i.ivl_hs : udesc_pkg::IVL_HS_DEF;
                if (nvm_ok_i)
                    eff_o.osc = nvm_i.cfg_fs;
            end
            udesc_pkg::UDESC_SS:
            begin
                eff_o.bulk_mps = udesc_pkg::MPS_SS;
                eff_o.int_ivl = udesc_pkg::IVL_SS;
                eff_o.osc_stall = 1'b1;
            end
            default:
            begin
                eff_o.osc_stall = 1'b1;
            end
        endcase
    end

endmodule : udesc_speed_sel

// ===== hdl/udesc_defaults.sv
// descriptor defaults: latches speed and image, answers descriptor byte requests
`timescale 1ns/100ps
module udesc_defaults (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    // bus enumeration
    input  wire logic                    enum_done_i,
    input  wire udesc_pkg::udesc_speed_e speed_i,
    // non-volatile image
    input  wire logic                    nvm_load_i,
    input  wire logic                    nvm_ok_i,
    input  wire udesc_pkg::udesc_nvm_s   nvm_i,
    // configuration flags
    input  wire logic                    self_powered_i,
    input  wire logic                    rwake_en_i,
    // descriptor request and answer
    input  wire logic                    req_valid_i,
    input  wire udesc_pkg::udesc_req_s   req_i,
    output udesc_pkg::udesc_rsp_s        rsp_o
);
    udesc_pkg::udesc_state_s st_r;
    udesc_pkg::udesc_state_s st_nxt;
    udesc_pkg::udesc_eff_s   eff;
    logic [7:0]              byte_val;
    logic                    byte_stall;

    udesc_speed_sel udesc_speed_sel_inst (
        .speed_i        (st_r.speed),
        .nvm_ok_i       (st_r.nvm_ok),
        .nvm_i          (st_r.nvm),
        .self_powered_i (self_powered_i),
        .rwake_en_i     (rwake_en_i),
        .eff_o          (eff)
    );

    // byte of the requested descriptor at the requested offset
    always_comb
    begin
        byte_val = udesc_pkg::BYTE_NONE;
        byte_stall = 1'b0;
        unique case (req_i.kind)
            udesc_pkg::UDESC_K_IFC:
            begin
                case (req_i.ofs)
                    udesc_pkg::OFS_LEN:      byte_val = udesc_pkg::IF_LEN;
                    udesc_pkg::OFS_TYPE:     byte_val = udesc_pkg::IF_TYPE;
                    udesc_pkg::OFS_IF_NUM:   byte_val = udesc_pkg::IF_NUM;
                    udesc_pkg::OFS_IF_ALT:   byte_val = udesc_pkg::IF_ALT;
                    udesc_pkg::OFS_IF_NEP:   byte_val = udesc_pkg::IF_NEP;
                    udesc_pkg::OFS_IF_CLASS: byte_val = eff.if_class;
                    udesc_pkg::OFS_IF_SUB:   byte_val = eff.if_sub;
                    udesc_pkg::OFS_IF_PROTO: byte_val = eff.if_proto;
                    udesc_pkg::OFS_IF_STR:   byte_val = eff.if_str;
                    default:                 byte_val = udesc_pkg::BYTE_NONE;
                endcase
            end
            udesc_pkg::UDESC_K_EPBI,
            udesc_pkg::UDESC_K_EPBO:
            begin
                case (req_i.ofs)
                    udesc_pkg::OFS_LEN:     byte_val = udesc_pkg::EP_LEN;
                    udesc_pkg::OFS_TYPE:    byte_val = udesc_pkg::EP_TYPE;
                    udesc_pkg::OFS_EP_ADDR:
                    begin
                        if (req_i.kind == udesc_pkg::UDESC_K_EPBI)
                            byte_val = udesc_pkg::EPBI_ADDR;
                        else
                            byte_val = udesc_pkg::EPBO_ADDR;
                    end
                    udesc_pkg::OFS_EP_ATTR: byte_val = udesc_pkg::EP_BULK_ATTR;
                    udesc_pkg::OFS_EP_MPSL: byte_val = udesc_pkg::udesc_half(eff.bulk_mps, 1'b0);
                    udesc_pkg::OFS_EP_MPSH: byte_val = udesc_pkg::udesc_half(eff.bulk_mps, 1'b1);
                    udesc_pkg::OFS_EP_IVL:  byte_val = udesc_pkg::EP_BULK_IVL;
                    default:                byte_val = udesc_pkg::BYTE_NONE;
                endcase
            end
            udesc_pkg::UDESC_K_EPIN:
            begin
                case (req_i.ofs)
                    udesc_pkg::OFS_LEN:     byte_val = udesc_pkg::EP_LEN;
                    udesc_pkg::OFS_TYPE:    byte_val = udesc_pkg::EP_TYPE;
                    udesc_pkg::OFS_EP_ADDR: byte_val = udesc_pkg::EPIN_ADDR;
                    udesc_pkg::OFS_EP_ATTR: byte_val = udesc_pkg::EPIN_ATTR;
                    udesc_pkg::OFS_EP_MPSL: byte_val = udesc_pkg::udesc_half(udesc_pkg::EPIN_MPS, 1'b0);
                    udesc_pkg::OFS_EP_MPSH: byte_val = udesc_pkg::udesc_half(udesc_pkg::EPIN_MPS, 1'b1);
                    udesc_pkg::OFS_EP_IVL:  byte_val = eff.int_ivl;
                    default:                byte_val = udesc_pkg::BYTE_NONE;
                endcase
            end
            udesc_pkg::UDESC_K_OSC:
            begin
                byte_stall = eff.osc_stall;
                case (req_i.ofs)
                    udesc_pkg::OFS_LEN:     byte_val = udesc_pkg::OSC_LEN;
                    udesc_pkg::OFS_TYPE:    byte_val = udesc_pkg::OSC_TYPE;
                    udesc_pkg::OFS_CF_TOTL: byte_val = udesc_pkg::udesc_half(udesc_pkg::OSC_TOTAL, 1'b0);
                    udesc_pkg::OFS_CF_TOTH: byte_val = udesc_pkg::udesc_half(udesc_pkg::OSC_TOTAL, 1'b1);
                    udesc_pkg::OFS_CF_NIF:  byte_val = udesc_pkg::OSC_NIF;
                    udesc_pkg::OFS_CF_VAL:  byte_val = udesc_pkg::OSC_CFGV;
                    udesc_pkg::OFS_CF_STR:  byte_val = eff.osc.str;
                    udesc_pkg::OFS_CF_ATTR: byte_val = eff.osc.attr;
                    udesc_pkg::OFS_CF_PWR:  byte_val = eff.osc.pwr;
                    default:                byte_val = udesc_pkg::BYTE_NONE;
                endcase
                if (eff.osc_stall)
                    byte_val = udesc_pkg::BYTE_NONE;
            end
            default:
            begin
                // unknown descriptor kind is refused
                byte_stall = 1'b1;
            end
        endcase
    end

    always_comb
    begin
        st_nxt = st_r;
        if (enum_done_i)
            st_nxt.speed = speed_i;
        // image is taken once; later load pulses are ignored until reset
        if (nvm_load_i && !st_r.nvm_held)
        begin
            st_nxt.nvm_held = 1'b1;
            st_nxt.nvm_ok = nvm_ok_i;
            st_nxt.nvm = nvm_i;
        end
        st_nxt.rsp.valid = req_valid_i;
        st_nxt.rsp.stall = req_valid_i & byte_stall;
        st_nxt.rsp.data = req_valid_i ? byte_val : udesc_pkg::BYTE_NONE;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            st_r <= '{speed: udesc_pkg::UDESC_FS, default: '0};
        else
            st_r <= st_nxt;
    end

    assign rsp_o = st_r.rsp;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_rsp_follows_req: assert property (req_valid_i |=> rsp_o.valid ##1 (rsp_o.valid == $past(req_valid_i)))
        else $error("answer does not follow request by one cycle");
    a_if_ep_count: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_IFC
        && req_i.ofs == udesc_pkg::OFS_IF_NEP |=> rsp_o.data == 8'h03 && !rsp_o.stall)
        else $error("interface endpoint count wrong");
    a_if_class_def: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_IFC
        && req_i.ofs == udesc_pkg::OFS_IF_CLASS && !st_r.nvm_ok |=> rsp_o.data == 8'hFF)
        else $error("interface class default wrong");
    a_bi_addr: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_EPBI
        && req_i.ofs == udesc_pkg::OFS_EP_ADDR |=> rsp_o.data == 8'h81)
        else $error("bulk-in address wrong");
    a_bo_addr: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_EPBO
        && req_i.ofs == udesc_pkg::OFS_EP_ADDR |=> rsp_o.data == 8'h02)
        else $error("bulk-out address wrong");
    a_bulk_mps_hs: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_EPBO
        && req_i.ofs == udesc_pkg::OFS_EP_MPSH && st_r.speed == udesc_pkg::UDESC_HS
        |=> rsp_o.data == 8'h02)
        else $error("high speed bulk packet size wrong");
    a_int_mps_low: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_EPIN
        && req_i.ofs == udesc_pkg::OFS_EP_MPSL |=> rsp_o.data == 8'h10)
        else $error("interrupt packet size wrong");
    a_int_ivl_ss: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_EPIN
        && req_i.ofs == udesc_pkg::OFS_EP_IVL && st_r.speed == udesc_pkg::UDESC_SS
        |=> rsp_o.data == 8'h06)
        else $error("SuperSpeed interrupt interval wrong");
    a_osc_stall_ss: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_OSC
        |=> rsp_o.stall == ($past(st_r.speed) == udesc_pkg::UDESC_SS))
        else $error("other-speed stall wrong");
    a_osc_total: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_OSC
        && req_i.ofs == udesc_pkg::OFS_CF_TOTL && st_r.speed != udesc_pkg::UDESC_SS
        |=> rsp_o.data == 8'h27)
        else $error("other-speed total length wrong");
    a_osc_attr_def: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_OSC
        && req_i.ofs == udesc_pkg::OFS_CF_ATTR && st_r.speed != udesc_pkg::UDESC_SS
        && !st_r.nvm_ok && self_powered_i && rwake_en_i |=> rsp_o.data == 8'hE0)
        else $error("other-speed attribute default wrong");
    a_osc_pwr_bus: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_OSC
        && req_i.ofs == udesc_pkg::OFS_CF_PWR && st_r.speed != udesc_pkg::UDESC_SS
        && !st_r.nvm_ok && !self_powered_i |=> rsp_o.data == 8'hFA)
        else $error("bus powered maximum power wrong");
    a_osc_opposite: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_OSC
        && req_i.ofs == udesc_pkg::OFS_CF_STR && st_r.speed == udesc_pkg::UDESC_FS
        && st_r.nvm_ok |=> rsp_o.data == $past(st_r.nvm.cfg_hs.str))
        else $error("other-speed fields not from high speed set");
    a_nvm_stable: assert property (st_r.nvm_held |=> st_r.nvm_held && $stable(st_r.nvm))
        else $error("loaded image changed before reset");
    a_bulk_mps_fs: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_EPBI
        && req_i.ofs == udesc_pkg::OFS_EP_MPSL && st_r.speed == udesc_pkg::UDESC_FS
        |=> rsp_o.data == 8'h40)
        else $error("full speed bulk packet size wrong");
    a_bulk_mps_ss: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_EPBI
        && req_i.ofs == udesc_pkg::OFS_EP_MPSH && st_r.speed == udesc_pkg::UDESC_SS
        |=> rsp_o.data == 8'h04)
        else $error("SuperSpeed bulk packet size wrong");
    a_ep_len: assert property (req_valid_i && req_i.kind inside {udesc_pkg::UDESC_K_EPBI,
        udesc_pkg::UDESC_K_EPBO, udesc_pkg::UDESC_K_EPIN}
        && req_i.ofs == udesc_pkg::OFS_LEN |=> rsp_o.data == 8'h07 && !rsp_o.stall)
        else $error("endpoint descriptor length wrong");
    a_int_ivl_hs: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_EPIN
        && req_i.ofs == udesc_pkg::OFS_EP_IVL && st_r.speed == udesc_pkg::UDESC_HS
        && !st_r.nvm_ok |=> rsp_o.data == 8'h04)
        else $error("high speed interrupt interval default wrong");
    a_osc_pwr_self: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_OSC
        && req_i.ofs == udesc_pkg::OFS_CF_PWR && st_r.speed != udesc_pkg::UDESC_SS
        && !st_r.nvm_ok && self_powered_i |=> rsp_o.data == 8'h01)
        else $error("self powered maximum power wrong");
    a_osc_type: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_OSC
        && req_i.ofs == udesc_pkg::OFS_TYPE && st_r.speed != udesc_pkg::UDESC_SS
        |=> rsp_o.data == 8'h07 && !rsp_o.stall)
        else $error("other-speed descriptor type wrong");
    a_if_sub_img: assert property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_IFC
        && req_i.ofs == udesc_pkg::OFS_IF_SUB && st_r.nvm_ok
        |=> rsp_o.data == $past(st_r.nvm.if_sub))
        else $error("interface subclass not from image");
    a_rsp_idle: assert property (!req_valid_i |=> !rsp_o.valid && !rsp_o.stall
        && rsp_o.data == 8'h00)
        else $error("answer shown without a request");

    c_osc_stalled: cover property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_OSC
        && st_r.speed == udesc_pkg::UDESC_SS);
    c_osc_fs_nvm: cover property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_OSC
        && st_r.speed == udesc_pkg::UDESC_FS && st_r.nvm_ok);
    c_int_hs: cover property (req_valid_i && req_i.kind == udesc_pkg::UDESC_K_EPIN
        && st_r.speed == udesc_pkg::UDESC_HS);
    c_speed_change: cover property (enum_done_i && speed_i != st_r.speed);
    c_img_refused: cover property (nvm_load_i && !nvm_ok_i && !st_r.nvm_held);

endmodule : udesc_defaults

// ===== tb/udesc_host_model.sv
// host side model: issues descriptor byte requests and takes the answers
`timescale 1ns/100ps
module udesc_host_model (
    // clock
    input  wire logic                  clk_i,
    // request and answer
    output logic                       req_valid_o,
    output udesc_pkg::udesc_req_s      req_o,
    input  wire udesc_pkg::udesc_rsp_s rsp_i
);
    initial
    begin
        req_valid_o = 1'b0;
        req_o       = '0;
    end

    // one strobe per byte; the answer stands for one cycle only
    task automatic fetch(input int k, input int o, output logic [7:0] d, output logic st,
                         output logic seen);
        int n;
        n = 0;
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_o       <= '{kind: udesc_pkg::udesc_kind_e'(k[2:0]), ofs: o[3:0]};
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        #1;
        while (rsp_i.valid !== 1'b1 && n < 4)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        seen = (rsp_i.valid === 1'b1);
        d    = rsp_i.data;
        st   = rsp_i.stall;
    endtask : fetch
endmodule : udesc_host_model

// ===== tb/test_udesc_defaults.sv
// self-checking testbench of the descriptor defaults block
`timescale 1ns/100ps
module test_udesc_defaults;
    logic                    clk_i = 1'b0;
    logic                    sys_rst_i = 1'b1;
    logic                    enum_done_i = 1'b0;
    udesc_pkg::udesc_speed_e speed_i = udesc_pkg::UDESC_FS;
    logic                    nvm_load_i = 1'b0;
    logic                    nvm_ok_i = 1'b0;
    udesc_pkg::udesc_nvm_s   nvm_i = '0;
    logic                    self_powered_i = 1'b1;
    logic                    rwake_en_i = 1'b1;
    logic                    req_valid;
    udesc_pkg::udesc_req_s   req;
    udesc_pkg::udesc_rsp_s   rsp;
    udesc_pkg::udesc_speed_e spd = udesc_pkg::UDESC_FS;
    logic                    ok = 1'b0;
    udesc_pkg::udesc_nvm_s   img = '0;
    int                      num_errors = 0;
    int                      num_checks = 0;

    always #2.5 clk_i = ~clk_i;

    udesc_defaults udesc_defaults_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .enum_done_i(enum_done_i), .speed_i(speed_i), .nvm_load_i(nvm_load_i),
        .nvm_ok_i(nvm_ok_i), .nvm_i(nvm_i), .self_powered_i(self_powered_i),
        .rwake_en_i(rwake_en_i), .req_valid_i(req_valid), .req_i(req), .rsp_o(rsp));
    udesc_host_model udesc_host_model_inst (.clk_i(clk_i), .req_valid_o(req_valid),
        .req_o(req), .rsp_i(rsp));

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : check_byte

    task automatic check_bit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : check_bit

    // expected byte of a descriptor under the current speed, image and flags
    function automatic logic [7:0] exp_byte(input int k, input int o);
        logic [15:0]          m;
        logic [7:0]           v;
        udesc_pkg::udesc_cfg_s c;
        logic [7:0]           b [0:9];
        m = (spd == udesc_pkg::UDESC_SS) ? 16'h0400 :
            (spd == udesc_pkg::UDESC_HS) ? 16'h0200 : 16'h0040;
        v = (spd == udesc_pkg::UDESC_SS) ? 8'h06 : (spd == udesc_pkg::UDESC_HS) ?
            (ok ? img.ivl_hs : 8'h04) : (ok ? img.ivl_fs : 8'h01);
        c = (spd == udesc_pkg::UDESC_HS) ? img.cfg_fs : img.cfg_hs;
        if (!ok)
            c = '{8'h00, {1'b1, self_powered_i, rwake_en_i, 5'h00},
                  self_powered_i ? 8'h01 : 8'hFA};
        b = '{default: 8'h00};
        case (k)
            0: b = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h03, ok ? img.if_class : 8'hFF,
                     ok ? img.if_sub : 8'h00, ok ? img.if_proto : 8'hFF,
                     ok ? img.if_str : 8'h00, 8'h00};
            1: b = '{8'h07, 8'h05, 8'h81, 8'h02, m[7:0], m[15:8], 8'h00, 8'h00, 8'h00, 8'h00};
            2: b = '{8'h07, 8'h05, 8'h02, 8'h02, m[7:0], m[15:8], 8'h00, 8'h00, 8'h00, 8'h00};
            3: b = '{8'h07, 8'h05, 8'h83, 8'h03, 8'h10, 8'h00, v, 8'h00, 8'h00, 8'h00};
            4: if (spd != udesc_pkg::UDESC_SS)
                b = '{8'h09, 8'h07, 8'h27, 8'h00, 8'h01, 8'h01, c.str, c.attr, c.pwr, 8'h00};
            default: b[0] = 8'h00;
        endcase
        return b[o];
    endfunction : exp_byte

    // reads every byte of every descriptor kind, one unknown kind included
    task automatic check_all();
        logic [7:0] d;
        logic       st;
        logic       seen;
        for (int k = 0; k < 6; k++)
            for (int o = 0; o < 10; o++)
            begin
                udesc_host_model_inst.fetch(k, o, d, st, seen);
                check_bit("valid", 1'b1, seen);
                if (!seen)
                    return;
                check_bit("stall", k > 4 || (k == 4 && spd == udesc_pkg::UDESC_SS), st);
                check_byte("data", exp_byte(k, o), d);
            end
    endtask : check_all

    task automatic enumerate(input udesc_pkg::udesc_speed_e s, input logic sp, input logic rw);
        @(posedge clk_i);
        enum_done_i    <= 1'b1;
        speed_i        <= s;
        self_powered_i <= sp;
        rwake_en_i     <= rw;
        @(posedge clk_i);
        enum_done_i <= 1'b0;
        spd = s;
    endtask : enumerate

    // image keeps the five fixed interface fields at their defaults by leaving them out
    task automatic load_image(input udesc_pkg::udesc_nvm_s v, input logic first,
                              input logic vok);
        @(posedge clk_i);
        nvm_load_i <= 1'b1;
        nvm_ok_i   <= vok;
        nvm_i      <= v;
        @(posedge clk_i);
        nvm_load_i <= 1'b0;
        if (first)
        begin
            ok  = vok;
            img = v;
        end
    endtask : load_image

    task automatic do_reset();
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        spd = udesc_pkg::UDESC_FS;
        ok  = 1'b0;
        img = '0;
    endtask : do_reset

    task automatic run_defaults();
        check_all();
        enumerate(udesc_pkg::UDESC_HS, 1'b0, 1'b0);
        check_all();
        enumerate(udesc_pkg::UDESC_SS, 1'b1, 1'b0);
        check_all();
    endtask : run_defaults

    task automatic run_image();
        enumerate(udesc_pkg::UDESC_HS, 1'b1, 1'b1);
        load_image(96'hA1B2C3040A08_05C032_06A064, 1'b1, 1'b1);
        check_all();
        enumerate(udesc_pkg::UDESC_FS, 1'b0, 1'b1);
        check_all();
        load_image(96'h111111111111_111111_111111, 1'b0, 1'b1);
        check_all();
        do_reset();
        check_all();
        load_image(96'h222222222222_222222_222222, 1'b1, 1'b0);
        check_all();
        load_image(96'h333333333333_333333_333333, 1'b0, 1'b1);
        check_all();
    endtask : run_image

    initial
    begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        run_defaults();
        run_image();
        close_out();
    end
endmodule : test_udesc_defaults
